// file: rtl/fcs_pkg.sv
// Purpose: shared types and constants for the configuration sequencer
// Assumes: 50 MHz mclk
// Notes: scheme codes, state codes and pll chain layout
package fcs_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CFG_MAX_MS = 100;
  localparam int unsigned CFG_MAX_CYC = CFG_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned BYTES_DEF = 1024;
  localparam int unsigned INIT_CYC = 16;
  localparam int unsigned PLL_W = 36;
  localparam int unsigned PLL_MUL_LSB = 0;
  localparam int unsigned PLL_DIV_LSB = 12;
  localparam int unsigned PLL_DLY_LSB = 24;
  localparam logic [11:0] PLL_MUL_RST = 12'h001;
  localparam logic [11:0] PLL_DIV_RST = 12'h001;
  localparam logic [11:0] PLL_DLY_RST = 12'h000;
  // arbitrary neutral identity value
  localparam logic [31:0] ID_CODE = 32'h0000_0001;

  typedef enum logic [2:0] {
    SCH_MEMDEV = 3'h0,
    SCH_PASSIVE_SERIAL = 3'h1,
    SCH_PASSIVE_PARALLEL_ASYNC = 3'h2,
    SCH_FAST_PARALLEL = 3'h3,
    SCH_BSCAN = 3'h4
  } fcs_scheme_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_CONFIG = 2'b01,
    ST_INIT = 2'b10,
    ST_USER = 2'b11
  } fcs_state_t;

  typedef struct packed {
    logic serial_bit;
    logic serial_clk;
    logic [7:0] par_data;
    logic par_clk;
    logic par_wr_n;
    logic par_cs_n;
  } fcs_cfg_pins_t;

  typedef struct packed {
    logic clk;
    logic data;
    logic update;
  } fcs_pll_pins_t;

endpackage

// file: rtl/fcs_sequencer.sv
// Purpose: configuration sequencer, command mode to user mode
// Assumes: one 50 MHz clock; all pin inputs are asynchronous
// Notes: a byte count sets the image length; no check value is verified
//
// Notes on behaviour
// - user I/O stays undriven from power-up through configuration and init until user mode
// - after last data, init resets user registers then enables I/O
// - state splits command mode (reset, config, init) from user mode
// - reconfig pin forces command mode, reload, reinit, back to user
// - data accepted via memory device, serial, async/fast parallel, scan
// - chain enable input gates loading, output passes enable on when done
// - byte-wide load at 50 MHz completes in under 100 ms
// - host may write serially or in parallel, sync or async, one address
// - pll counters reloaded through a serial chain from logic or pins
// - pll chain reload never disturbs the user-mode state
// - memory device scheme starts loading at power-up without a host
// - reconfig pin low or scan pulse instruction starts a new load
module fcs_sequencer #(
  parameter int unsigned BYTES = fcs_pkg::BYTES_DEF,
  parameter int unsigned TIMEOUT_CYC = fcs_pkg::CFG_MAX_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] scheme_sel,
  input wire logic chain_enable_in_n,
  input wire logic reconfig_request_n,
  input wire logic scan_pulse_reconfig,
  input wire logic [7:0] scan_data,
  input wire logic scan_valid,
  input wire fcs_pkg::fcs_cfg_pins_t cfg_pins,
  input wire fcs_pkg::fcs_pll_pins_t pll_pins,
  input wire logic pll_from_logic,
  input wire fcs_pkg::fcs_pll_pins_t pll_logic,
  output logic chain_enable_out_n,
  output logic user_mode,
  output logic io_enable,
  output logic user_reset,
  output logic cfg_error,
  output logic [7:0] cfg_byte,
  output logic cfg_byte_valid,
  output logic [11:0] pll_mul,
  output logic [11:0] pll_div,
  output logic [11:0] pll_dly
);

  localparam int unsigned SYNW = 18;
  // idle pin levels: edge detectors must see no edge right after reset
  localparam logic [SYNW-1:0] SYNC_IDLE = 18'h3_0018;

  logic [1:0] rst_sync_q;
  logic rst_i_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_i_n = rst_sync_q[1];

  // all pin inputs pass two flops before use
  logic [SYNW-1:0] raw_w, s1_q, s2_q, s3_q;
  assign raw_w = {chain_enable_in_n, reconfig_request_n, cfg_pins,
                  pll_pins};
  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
      s3_q <= SYNC_IDLE;
    end else begin
      s1_q <= raw_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic ce_n_s, recfg_n_s;
  fcs_pkg::fcs_cfg_pins_t cp_s, cp_p;
  fcs_pkg::fcs_pll_pins_t pp_s, pp_p;
  assign ce_n_s = s2_q[17];
  assign recfg_n_s = s2_q[16];
  assign cp_s = s2_q[15:3];
  assign pp_s = s2_q[2:0];
  assign cp_p = s3_q[15:3];
  assign pp_p = s3_q[2:0];

  fcs_pkg::fcs_scheme_t scheme_w;
  assign scheme_w = fcs_pkg::fcs_scheme_t'(scheme_sel);

  fcs_pkg::fcs_state_t st_q, st_d;
  logic [31:0] cnt_q;
  logic [31:0] tmo_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic recfg_s3;
  assign recfg_s3 = s3_q[16];

  // one load stream: each scheme yields byte strobes
  logic ser_edge, par_edge, async_wr, bs_w, byte_done;
  logic [7:0] byte_w;
  assign ser_edge = cp_s.serial_clk & ~cp_p.serial_clk;
  assign par_edge = cp_s.par_clk & ~cp_p.par_clk;
  assign async_wr = cp_s.par_wr_n & ~cp_p.par_wr_n & ~cp_s.par_cs_n;
  assign bs_w = (scheme_w == fcs_pkg::SCH_MEMDEV ||
                 scheme_w == fcs_pkg::SCH_PASSIVE_SERIAL) && ser_edge
                && bit_q == 3'd7;
  always_comb begin
    byte_done = 1'b0;
    byte_w = cp_s.par_data;
    unique case (scheme_w)
      fcs_pkg::SCH_MEMDEV, fcs_pkg::SCH_PASSIVE_SERIAL: begin
        byte_done = bs_w;
        byte_w = {cp_s.serial_bit, sh_q[7:1]};
      end
      fcs_pkg::SCH_PASSIVE_PARALLEL_ASYNC: byte_done = async_wr;
      fcs_pkg::SCH_FAST_PARALLEL: byte_done = par_edge;
      fcs_pkg::SCH_BSCAN: begin
        byte_done = scan_valid;
        byte_w = scan_data;
      end
      default: byte_done = 1'b0;
    endcase
  end

  logic loading, restart, last_byte, tmo_hit;
  assign loading = st_q == fcs_pkg::ST_CONFIG && !ce_n_s;
  // pin low or scan instruction, edge of falling request
  assign restart = (!recfg_n_s && recfg_s3) || scan_pulse_reconfig;
  assign last_byte = loading && byte_done && cnt_q == 32'(BYTES - 1);
  assign tmo_hit = tmo_q == 32'(TIMEOUT_CYC - 1);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      fcs_pkg::ST_RESET: st_d = fcs_pkg::ST_CONFIG;
      fcs_pkg::ST_CONFIG: if (last_byte) st_d = fcs_pkg::ST_INIT;
      fcs_pkg::ST_INIT:
        if (cnt_q == 32'(fcs_pkg::INIT_CYC - 1)) st_d = fcs_pkg::ST_USER;
      fcs_pkg::ST_USER: st_d = fcs_pkg::ST_USER;
    endcase
    if (restart) st_d = fcs_pkg::ST_RESET;
  end

  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      st_q <= fcs_pkg::ST_RESET;
      cnt_q <= '0;
      tmo_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      cfg_error <= 1'b0;
      cfg_byte <= '0;
      cfg_byte_valid <= 1'b0;
    end else begin
      st_q <= st_d;
      cfg_byte_valid <= loading && byte_done && !restart;
      if (byte_done) cfg_byte <= byte_w;
      if (st_d != st_q) cnt_q <= '0;
      else if (st_q == fcs_pkg::ST_INIT || (loading && byte_done))
        cnt_q <= cnt_q + 32'd1;
      if (ser_edge && loading) begin
        sh_q <= {cp_s.serial_bit, sh_q[7:1]};
        bit_q <= bit_q + 3'd1;
      end
      if (st_q != fcs_pkg::ST_CONFIG || ce_n_s) tmo_q <= '0;
      else if (!tmo_hit) tmo_q <= tmo_q + 32'd1;
      // a load that overruns its budget is flagged
      if (restart) cfg_error <= 1'b0;
      else if (tmo_hit && st_q == fcs_pkg::ST_CONFIG) cfg_error <= 1'b1;
      if (st_q == fcs_pkg::ST_RESET) begin
        bit_q <= '0;
        sh_q <= '0;
      end
    end
  end

  // outputs registered from state
  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      user_mode <= 1'b0;
      io_enable <= 1'b0;
      user_reset <= 1'b1;
      chain_enable_out_n <= 1'b1;
    end else begin
      user_mode <= st_d == fcs_pkg::ST_USER;
      io_enable <= st_d == fcs_pkg::ST_USER;
      user_reset <= st_d != fcs_pkg::ST_USER;
      chain_enable_out_n <= !(st_d == fcs_pkg::ST_INIT ||
                              st_d == fcs_pkg::ST_USER);
    end
  end

  // pll chain runs independently of the main state machine
  fcs_pkg::fcs_pll_pins_t pl_src;
  logic pl_clk_p, pl_upd_p, pl_sh_e, pl_up_e;
  logic [fcs_pkg::PLL_W-1:0] pl_sh_q;
  logic [11:0] pl_mul_w;
  assign pl_mul_w = pl_sh_q[fcs_pkg::PLL_MUL_LSB +: 12];
  assign pl_src = pll_from_logic ? pll_logic : pp_s;
  assign pl_sh_e = pl_src.clk & ~pl_clk_p;
  assign pl_up_e = pl_src.update & ~pl_upd_p;
  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      pl_clk_p <= 1'b0;
      pl_upd_p <= 1'b0;
      pl_sh_q <= '0;
      pll_mul <= fcs_pkg::PLL_MUL_RST;
      pll_div <= fcs_pkg::PLL_DIV_RST;
      pll_dly <= fcs_pkg::PLL_DLY_RST;
    end else begin
      pl_clk_p <= pl_src.clk;
      pl_upd_p <= pl_src.update;
      if (pl_sh_e)
        pl_sh_q <= {pl_src.data, pl_sh_q[fcs_pkg::PLL_W-1:1]};
      if (pl_up_e) begin
        pll_mul <= pl_sh_q[fcs_pkg::PLL_MUL_LSB +: 12];
        pll_div <= pl_sh_q[fcs_pkg::PLL_DIV_LSB +: 12];
        pll_dly <= pl_sh_q[fcs_pkg::PLL_DLY_LSB +: 12];
      end
    end
  end

  // checks
  // cycles spent in init; a counter instead of a long repetition
  logic [4:0] init_run_q;
  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) init_run_q <= '0;
    else if (st_q == fcs_pkg::ST_INIT) init_run_q <= init_run_q + 5'd1;
    else init_run_q <= '0;
  end

  property p_io_off_cmd;
    @(posedge mclk) disable iff (!rst_i_n)
      !user_mode |-> !io_enable;
  endproperty
  a_io_off_cmd: assert property (p_io_off_cmd)
    else $error("io enabled outside user mode");

  property p_user_after_init;
    @(posedge mclk) disable iff (!rst_i_n)
      $rose(user_mode) |-> $past(st_q) == fcs_pkg::ST_INIT;
  endproperty
  a_user_after_init: assert property (p_user_after_init)
    else $error("user mode entered not from init");

  property p_init_len;
    @(posedge mclk) disable iff (!rst_i_n)
      $rose(user_mode) |-> init_run_q == 5'(fcs_pkg::INIT_CYC);
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("init length differs from the init cycle count");

  property p_init_end;
    @(posedge mclk) disable iff (!rst_i_n)
      (st_q == fcs_pkg::ST_CONFIG && st_d == fcs_pkg::ST_INIT)
      |-> ##[1:17] (user_mode || restart);
  endproperty
  a_init_end: assert property (p_init_end)
    else $error("init did not finish in time");

  property p_restart;
    @(posedge mclk) disable iff (!rst_i_n)
      restart |=> !user_mode && !io_enable;
  endproperty
  a_restart: assert property (p_restart)
    else $error("reconfig did not return to command mode");

  property p_chain;
    @(posedge mclk) disable iff (!rst_i_n)
      !chain_enable_out_n |-> st_q != fcs_pkg::ST_CONFIG;
  endproperty
  a_chain: assert property (p_chain)
    else $error("chain enable passed during load");

  property p_hold_ce;
    @(posedge mclk) disable iff (!rst_i_n)
      ce_n_s |=> !cfg_byte_valid;
  endproperty
  a_hold_ce: assert property (p_hold_ce)
    else $error("byte taken while chain disabled");

  property p_mode;
    @(posedge mclk) disable iff (!rst_i_n)
      user_mode == (st_q == fcs_pkg::ST_USER);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode output disagrees with state");

  property p_pll_keep;
    @(posedge mclk) disable iff (!rst_i_n)
      user_mode && pl_up_e && !restart |=> user_mode;
  endproperty
  a_pll_keep: assert property (p_pll_keep)
    else $error("pll reload disturbed user mode");

  property p_pll_load;
    @(posedge mclk) disable iff (!rst_i_n)
      pl_up_e |=> pll_mul == $past(pl_mul_w);
  endproperty
  a_pll_load: assert property (p_pll_load)
    else $error("pll counter not loaded");

  c_user: cover property (@(posedge mclk) $rose(user_mode));
  c_reload: cover property (@(posedge mclk) user_mode ##1 restart);
  c_pll: cover property (@(posedge mclk) user_mode && pl_up_e);
  c_err: cover property (@(posedge mclk) $rose(cfg_error));
  c_wait: cover property (@(posedge mclk) ce_n_s && st_q == fcs_pkg::ST_CONFIG);

endmodule

// file: testbench/fcs_cfg_host.sv
// Purpose: configuration data source on the far side of the sequencer
// Assumes: pin edges are kept at least 3 mclk apart
// Notes: a released data line shows the inverse of its last value
module fcs_cfg_host (
  input wire logic mclk,
  output fcs_pkg::fcs_cfg_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    pins = '0;
    pins.par_wr_n = 1'b1;
    pins.par_cs_n = 1'b1;
  end

  task automatic hold3;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // memory device and serial host share the serial pins, lsb first
  task automatic put(input logic [2:0] s, input logic [7:0] b);
    if (s < 3'h2) begin
      for (int i = 0; i < 8; i++) begin
        pins.serial_bit = b[i];
        hold3();
        pins.serial_clk = 1'b1;
        hold3();
        pins.serial_clk = 1'b0;
      end
      pins.serial_bit = ~b[7];
    end else if (s == 3'h3) begin
      pins.par_data = b;
      hold3();
      pins.par_clk = 1'b1;
      hold3();
      pins.par_clk = 1'b0;
    end else begin
      pins.par_cs_n = 1'b0;
      pins.par_data = b;
      pins.par_wr_n = 1'b0;
      hold3();
      pins.par_wr_n = 1'b1;
      hold3();
      pins.par_cs_n = 1'b1;
    end
    hold3();
    pins.par_data = ~b;
  endtask
endmodule

// file: testbench/fcs_sequencer_tb.sv
// Purpose: self-checking bench for the configuration sequencer
// Assumes: short image of 4 bytes and a 400 cycle load limit
// Notes: a monitor counts every accepted byte
module fcs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NB = 4;
  localparam int unsigned TO = 400;
  logic mclk, rst_n, chain_enable_in_n, reconfig_request_n;
  logic scan_pulse_reconfig, scan_valid, pll_from_logic;
  logic [2:0] scheme_sel;
  logic [7:0] scan_data, cfg_byte, last_b;
  fcs_pkg::fcs_cfg_pins_t cfg_pins;
  fcs_pkg::fcs_pll_pins_t pll_pins, pll_logic;
  logic chain_enable_out_n, user_mode, io_enable, user_reset, cfg_error;
  logic cfg_byte_valid;
  logic [11:0] pll_mul, pll_div, pll_dly;
  int fail_count, checks, nseen;

  fcs_sequencer #(.BYTES(NB), .TIMEOUT_CYC(TO)) dut (.mclk, .rst_n,
    .scheme_sel, .chain_enable_in_n, .reconfig_request_n,
    .scan_pulse_reconfig, .scan_data, .scan_valid, .cfg_pins, .pll_pins,
    .pll_from_logic, .pll_logic, .chain_enable_out_n, .user_mode,
    .io_enable, .user_reset, .cfg_error, .cfg_byte, .cfg_byte_valid,
    .pll_mul, .pll_div, .pll_dly);
  fcs_cfg_host host (.mclk, .pins(cfg_pins));

  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (cfg_byte_valid === 1'b1) begin
      nseen <= nseen + 1;
      last_b <= cfg_byte;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic restart_scan;
    scan_pulse_reconfig = 1'b1;
    cyc(1);
    scan_pulse_reconfig = 1'b0;
    cyc(3);
  endtask
  task automatic send(input logic [2:0] s, input logic [7:0] b);
    int n0;
    n0 = nseen;
    if (s == 3'h4) begin
      scan_data = b;
      scan_valid = 1'b1;
      cyc(1);
      scan_valid = 1'b0;
      scan_data = ~b;
    end else host.put(s, b);
    cyc(3);
    chk(nseen - n0, 1);
    chk(last_b, b);
  endtask
  // full image; user mode must wait for the last byte and for init
  task automatic load(input logic [2:0] s);
    int w;
    for (int i = 0; i < NB; i++) begin
      send(s, 8'h5a ^ 8'(i * 37));
      chk(user_mode, 0);
      chk(io_enable, 0);
    end
    chk(chain_enable_out_n, 0);
    w = 0;
    while (user_mode !== 1'b1 && w < 40) begin
      cyc(1);
      w++;
    end
    chk(user_mode, 1);
    chk(io_enable, 1);
    chk(user_reset, 0);
    chk(cfg_error, 0);
  endtask
  task automatic t_schemes;
    logic [35:0] rst_pll;
    rst_pll = {fcs_pkg::PLL_DLY_RST, fcs_pkg::PLL_DIV_RST,
               fcs_pkg::PLL_MUL_RST};
    for (int s = 0; s < 5; s++) begin
      rst_n = 1'b0;
      scheme_sel = 3'(s);
      cyc(4);
      rst_n = 1'b1;
      cyc(6);
      chk(user_reset, 1);
      chk(chain_enable_out_n, 1);
      chk({pll_dly, pll_div, pll_mul}, rst_pll);
      load(3'(s));
    end
  endtask
  task automatic t_restart;
    reconfig_request_n = 1'b0;
    cyc(5);
    chk(user_mode, 0);
    chk(io_enable, 0);
    reconfig_request_n = 1'b1;
    load(3'h4);
    restart_scan();
    chk(user_mode, 0);
    load(3'h4);
  endtask
  task automatic t_chain;
    int n0;
    chain_enable_in_n = 1'b1;
    restart_scan();
    n0 = nseen;
    send_drop();
    chk(nseen - n0, 0);
    chk(chain_enable_out_n, 1);
    chain_enable_in_n = 1'b0;
    // the enable pin passes two flops before loading may start
    cyc(3);
    load(3'h4);
  endtask
  task automatic send_drop;
    scan_valid = 1'b1;
    cyc(1);
    scan_valid = 1'b0;
    cyc(30);
  endtask
  task automatic t_timeout;
    restart_scan();
    cyc(TO + 20);
    chk(cfg_error, 1);
    restart_scan();
    chk(cfg_error, 0);
    load(3'h4);
  endtask
  task automatic t_pll(input logic sel, input logic [35:0] v);
    pll_from_logic = sel;
    for (int i = 0; i < 36; i++) begin
      pll_pins.data = v[i];
      pll_logic.data = v[i];
      cyc(3);
      pll_pins.clk = 1'b1;
      pll_logic.clk = 1'b1;
      cyc(3);
      pll_pins.clk = 1'b0;
      pll_logic.clk = 1'b0;
    end
    pll_pins.update = 1'b1;
    pll_logic.update = 1'b1;
    cyc(3);
    pll_pins.update = 1'b0;
    pll_logic.update = 1'b0;
    cyc(4);
    chk({pll_dly, pll_div, pll_mul}, v);
    chk({user_mode, io_enable}, 2'b11);
  endtask

  initial begin
    cyc(20000);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    scheme_sel = 3'h0;
    chain_enable_in_n = 1'b0;
    reconfig_request_n = 1'b1;
    scan_pulse_reconfig = 1'b0;
    scan_data = 8'h00;
    scan_valid = 1'b0;
    pll_pins = '0;
    pll_logic = '0;
    pll_from_logic = 1'b0;
    fail_count = 0;
    checks = 0;
    nseen = 0;
    t_schemes();
    t_restart();
    t_chain();
    t_timeout();
    t_pll(1'b0, 36'h9c3_a5f_7e1);
    t_pll(1'b1, 36'h246_8ac_135);
    close_out();
  end
endmodule
